// [design/msr_pkg.sv]
package msr_pkg;
  // ==========================================================
  // register word indices (byte address is index times four)
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_SETF = 4'h1;
  localparam logic [3:0] IDX_START = 4'h2;
  localparam logic [3:0] IDX_BRAKE = 4'h3;
  localparam logic [3:0] IDX_PREEX = 4'h4;
  localparam logic [3:0] IDX_SEARCH = 4'h5;
  localparam logic [3:0] IDX_GAIN = 4'h6;
  localparam logic [3:0] IDX_ACCDEC = 4'h7;
  localparam logic [3:0] IDX_SACC = 4'h8;
  localparam logic [3:0] IDX_SDEC = 4'h9;
  localparam logic [3:0] IDX_MOTOR = 4'hA;
  localparam logic [3:0] IDX_STAT = 4'hB;
  localparam logic [3:0] IDX_FREQ = 4'hC;
  localparam int CFG_N = 11;
  // ==========================================================
  // control word fields
  localparam int RUN_BIT = 0;
  localparam int REV_BIT = 1;
  localparam int METHOD_BIT = 2;
  localparam int STOPM_BIT = 3;
  localparam int SHAPE_LSB = 4;
  localparam int TRES_LSB = 6;
  // ==========================================================
  // reset values of the writable words
  localparam logic [31:0] CFG_RST [0:10] = '{
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_03E8,
    32'h000A_03E8, 32'h01F4_1400, 32'h0000_0064, 32'h0064_0064,
    32'h0064_0064, 32'h0064_0064, 32'h1388_1388};
  // ==========================================================
  // timing: one control tick is 0.01 s, so 0.01 s time fields count ticks
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 10_000_000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam logic [19:0] DECI_TICKS = 20'h0000A;
  localparam logic [63:0] GAIN_UNITY = 64'h0000_0000_0000_0064;
  localparam logic [31:0] SLOPE_FLOOR = 32'h0000_0100;
  // ==========================================================
  typedef enum logic [2:0] {
    PH_IDLE, PH_BRAKE, PH_PREEX, PH_HOLD, PH_SEARCH, PH_RUN, PH_STOP
  } msr_phase_type;
endpackage : msr_pkg

// [design/msr_start_ramp.sv]
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/1ns
// Overview of operation
// - direct start: brake, preexcite, start frequency, hold, ramp
// - zero brake time skips start braking
// - braking drives programmed current until time expires
// - preexcite current applied for programmed time
// - zero preexcite time skips preexcitation
// - start frequency held for hold time, then ramp
// - start frequency not clamped by lower limit
// - tracking start resumes from found motor speed
// - search origin: max, last stop, line frequency
// - tens zero: one direction, else zero speed
// - tens one: retry search in opposite direction
// - scan rate: rated frequency over tracking time
// - tracking current limited to programmed percentage
// - scan response scaled by compensation gain
// - shape zero ramps linearly at accel/decel slope
// - continuous S curve rounds both ramp ends
// - S segment time capped at half ramp time
// - intermittent S curve replans on a setpoint or ramp time write
// - stop method selects ramp or coast; stops during brake, preexcite, hold or search always coast
// - coast stop cuts output at once
module msr_start_ramp #(
  parameter int unsigned TICK_CYCLES = msr_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // from current control
  input wire logic speed_match,
  // to modulation stage
  output logic [15:0] freq_ref,
  output logic rev_dir,
  output logic out_enable,
  output logic dc_brake,
  output logic preexcite,
  output logic search_active,
  output logic [15:0] current_ref,
  output logic [15:0] search_gain
);
  // ==========================================================
  // state
  logic [31:0] cfg_ff [0:msr_pkg::CFG_N-1];
  msr_pkg::msr_phase_type phase_ff;
  logic [31:0] cur_ff, slope_ff, tick_cnt_ff, hrdata_ff;
  logic [15:0] timer_ff, last_stop_ff, freq_ref_ff, current_ref_ff, search_gain_ff;
  logic dir_ff, flipped_ff, tick_ff, replan_ff, wr_pend_ff, wr_hit_ff;
  logic [3:0] wr_idx_ff;
  logic hreadyout_ff, hresp_ff, rev_dir_ff, out_enable_ff;
  logic dc_brake_ff, preexcite_ff, search_active_ff;
  // ==========================================================
  // configuration fields
  logic run_cmd, rev_cmd, method_search, stop_coast, tens_one;
  logic [1:0] shape, tres;
  logic [3:0] ones;
  logic [15:0] set_f, start_f, hold_t, brake_cur, brake_t, preex_cur, preex_t;
  logic [15:0] srch_cur, srch_t, gain, acc_t, dec_t, max_f, line_f, origin;
  assign run_cmd = cfg_ff[msr_pkg::IDX_CTRL][msr_pkg::RUN_BIT];
  assign rev_cmd = cfg_ff[msr_pkg::IDX_CTRL][msr_pkg::REV_BIT];
  assign method_search = cfg_ff[msr_pkg::IDX_CTRL][msr_pkg::METHOD_BIT];
  assign stop_coast = cfg_ff[msr_pkg::IDX_CTRL][msr_pkg::STOPM_BIT];
  assign shape = cfg_ff[msr_pkg::IDX_CTRL][msr_pkg::SHAPE_LSB +: 2];
  assign tres = cfg_ff[msr_pkg::IDX_CTRL][msr_pkg::TRES_LSB +: 2];
  assign set_f = cfg_ff[msr_pkg::IDX_SETF][15:0];
  assign start_f = cfg_ff[msr_pkg::IDX_START][15:0];
  assign hold_t = cfg_ff[msr_pkg::IDX_START][31:16];
  assign brake_cur = cfg_ff[msr_pkg::IDX_BRAKE][15:0];
  assign brake_t = cfg_ff[msr_pkg::IDX_BRAKE][31:16];
  assign preex_cur = cfg_ff[msr_pkg::IDX_PREEX][15:0];
  assign preex_t = cfg_ff[msr_pkg::IDX_PREEX][31:16];
  assign ones = cfg_ff[msr_pkg::IDX_SEARCH][3:0];
  assign tens_one = cfg_ff[msr_pkg::IDX_SEARCH][7:4] == 4'h1;
  assign srch_t = {8'h00, cfg_ff[msr_pkg::IDX_SEARCH][15:8]};
  assign srch_cur = cfg_ff[msr_pkg::IDX_SEARCH][31:16];
  assign gain = cfg_ff[msr_pkg::IDX_GAIN][15:0];
  assign acc_t = cfg_ff[msr_pkg::IDX_ACCDEC][15:0];
  assign dec_t = cfg_ff[msr_pkg::IDX_ACCDEC][31:16];
  assign max_f = cfg_ff[msr_pkg::IDX_MOTOR][15:0];
  assign line_f = cfg_ff[msr_pkg::IDX_MOTOR][31:16];
  // search origin by the ones digit; unknown digits fall back to maximum
  assign origin = (ones == 4'h1) ? last_stop_ff : (ones == 4'h2) ? line_f : max_f;
  // ==========================================================
  // helpers: 16.16 slope per tick, and capped S segment length in ticks
  function automatic logic [31:0] rate_of(input logic [15:0] f, input logic [15:0] t);
    logic [19:0] d;
    d = 20'(t) * msr_pkg::DECI_TICKS;
    rate_of = (d == 20'h00000) ? {f, 16'h0000} : {f, 16'h0000} / 32'(d);
  endfunction : rate_of
  function automatic logic [23:0] seg_of(input logic [15:0] c, input logic [1:0] r,
                                         input logic [15:0] sys_t);
    logic [23:0] t;
    logic [23:0] half;
    t = (r == 2'h0) ? 24'(c) : (r == 2'h1) ? 24'(c) * 24'h00000A : 24'(c) * 24'h000064;
    half = (24'(sys_t) * 24'h00000A) >> 1;
    seg_of = (t > half) ? half : t;
  endfunction : seg_of
  // ==========================================================
  // control tick divider
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_ff <= 32'h0000_0000;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= tick_cnt_ff == 32'(TICK_CYCLES - 1);
      tick_cnt_ff <= (tick_cnt_ff == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : tick_cnt_ff + 32'h1;
    end
  end
  // ==========================================================
  // ramp planner, evaluated every cycle and applied on ticks
  logic up;
  logic [31:0] tgt32, rate, remaining, inc, dec, nxt_slope, nxt_cur, srate, sstep;
  logic [23:0] t_in, t_out;
  logic [63:0] gprod;
  always_comb begin
    tgt32 = (phase_ff == msr_pkg::PH_STOP) ? 32'h0000_0000 : {set_f, 16'h0000};
    up = cur_ff < tgt32;
    rate = up ? rate_of(max_f, acc_t) : rate_of(max_f, dec_t);
    t_in = up ? seg_of(cfg_ff[msr_pkg::IDX_SACC][15:0], tres, acc_t)
              : seg_of(cfg_ff[msr_pkg::IDX_SDEC][15:0], tres, dec_t);
    t_out = up ? seg_of(cfg_ff[msr_pkg::IDX_SACC][31:16], tres, acc_t)
               : seg_of(cfg_ff[msr_pkg::IDX_SDEC][31:16], tres, dec_t);
    remaining = up ? tgt32 - cur_ff : cur_ff - tgt32;
    inc = (t_in == 24'h000000) ? rate : rate / 32'(t_in);
    dec = (t_out == 24'h000000) ? slope_ff : rate / 32'(t_out);
    if (shape == 2'h0) begin
      nxt_slope = rate;
    end else if (64'({remaining, 1'b0}) <= 64'(slope_ff) * 64'(t_out)) begin
      // rounding the end; a floor keeps the ramp from stalling short of target
      nxt_slope = (slope_ff > dec + msr_pkg::SLOPE_FLOOR) ? slope_ff - dec
                                                          : msr_pkg::SLOPE_FLOOR;
    end else begin
      nxt_slope = (slope_ff + inc > rate) ? rate : slope_ff + inc;
    end
    nxt_cur = (remaining <= nxt_slope) ? tgt32 : up ? cur_ff + nxt_slope : cur_ff - nxt_slope;
    // scan slope: rated frequency down to zero over the tracking time
    srate = rate_of(max_f, srch_t);
    gprod = 64'(srate) * 64'(gain);
    sstep = 32'(gprod / msr_pkg::GAIN_UNITY);
    if (sstep < msr_pkg::SLOPE_FLOOR) begin
      sstep = msr_pkg::SLOPE_FLOOR;
    end
  end
  // ==========================================================
  // phase chain with zero-length phases skipped in the same step
  msr_pkg::msr_phase_type after_preex, after_brake, first_direct;
  assign after_preex = (hold_t != 16'h0000) ? msr_pkg::PH_HOLD : msr_pkg::PH_RUN;
  assign after_brake = (preex_t != 16'h0000) ? msr_pkg::PH_PREEX : after_preex;
  assign first_direct = (brake_t != 16'h0000) ? msr_pkg::PH_BRAKE : after_brake;
  // ==========================================================
  // start and stop sequencer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_ff <= msr_pkg::PH_IDLE;
      cur_ff <= 32'h0000_0000;
      slope_ff <= 32'h0000_0000;
      timer_ff <= 16'h0000;
      last_stop_ff <= 16'h0000;
      dir_ff <= 1'b0;
      flipped_ff <= 1'b0;
    end else if (phase_ff != msr_pkg::PH_IDLE && !run_cmd && (stop_coast ||
                 (phase_ff != msr_pkg::PH_RUN && phase_ff != msr_pkg::PH_STOP))) begin
      // coast: drop output now, no waiting for a tick
      phase_ff <= msr_pkg::PH_IDLE;
      last_stop_ff <= cur_ff[31:16];
      cur_ff <= 32'h0000_0000;
      slope_ff <= 32'h0000_0000;
    end else if (phase_ff == msr_pkg::PH_RUN && !run_cmd) begin
      phase_ff <= msr_pkg::PH_STOP;
      last_stop_ff <= cur_ff[31:16];
    end else if (phase_ff == msr_pkg::PH_STOP && run_cmd) begin
      phase_ff <= msr_pkg::PH_RUN;
    end else if (replan_ff) begin
      slope_ff <= 32'h0000_0000;
    end else begin
      unique case (phase_ff)
        msr_pkg::PH_IDLE: begin
          timer_ff <= 16'h0000;
          slope_ff <= 32'h0000_0000;
          flipped_ff <= 1'b0;
          dir_ff <= rev_cmd;
          if (run_cmd && method_search) begin
            phase_ff <= msr_pkg::PH_SEARCH;
            cur_ff <= {origin, 16'h0000};
          end else if (run_cmd) begin
            phase_ff <= first_direct;
            cur_ff <= {start_f, 16'h0000};
          end
        end
        msr_pkg::PH_BRAKE: begin
          if (tick_ff && timer_ff + 16'h0001 >= brake_t) begin
            phase_ff <= after_brake;
            timer_ff <= 16'h0000;
          end else if (tick_ff) begin
            timer_ff <= timer_ff + 16'h0001;
          end
        end
        msr_pkg::PH_PREEX: begin
          if (tick_ff && timer_ff + 16'h0001 >= preex_t) begin
            phase_ff <= after_preex;
            timer_ff <= 16'h0000;
          end else if (tick_ff) begin
            timer_ff <= timer_ff + 16'h0001;
          end
        end
        msr_pkg::PH_HOLD: begin
          if (tick_ff && timer_ff + 16'h0001 >= hold_t) begin
            phase_ff <= msr_pkg::PH_RUN;
          end else if (tick_ff) begin
            timer_ff <= timer_ff + 16'h0001;
          end
        end
        msr_pkg::PH_SEARCH: begin
          if (tick_ff && speed_match) begin
            phase_ff <= msr_pkg::PH_RUN;
          end else if (tick_ff && cur_ff <= sstep && tens_one && !flipped_ff) begin
            dir_ff <= ~dir_ff;
            flipped_ff <= 1'b1;
            cur_ff <= {origin, 16'h0000};
          end else if (tick_ff && cur_ff <= sstep) begin
            phase_ff <= msr_pkg::PH_RUN;
            cur_ff <= 32'h0000_0000;
            dir_ff <= rev_cmd;
          end else if (tick_ff) begin
            cur_ff <= cur_ff - sstep;
          end
        end
        msr_pkg::PH_RUN, msr_pkg::PH_STOP: begin
          if (tick_ff) begin
            cur_ff <= nxt_cur;
            slope_ff <= nxt_slope;
            if (phase_ff == msr_pkg::PH_STOP && nxt_cur == 32'h0000_0000) begin
              phase_ff <= msr_pkg::PH_IDLE;
            end
          end
        end
        default: phase_ff <= msr_pkg::PH_IDLE;
      endcase
    end
  end
  // ==========================================================
  // outputs to the modulation stage
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      freq_ref_ff <= 16'h0000;
      current_ref_ff <= 16'h0000;
      search_gain_ff <= 16'h0000;
      rev_dir_ff <= 1'b0;
      out_enable_ff <= 1'b0;
      dc_brake_ff <= 1'b0;
      preexcite_ff <= 1'b0;
      search_active_ff <= 1'b0;
    end else begin
      // no frequency while braking or building flux
      freq_ref_ff <= (phase_ff == msr_pkg::PH_IDLE || phase_ff == msr_pkg::PH_BRAKE ||
                      phase_ff == msr_pkg::PH_PREEX) ? 16'h0000 : cur_ff[31:16];
      current_ref_ff <= (phase_ff == msr_pkg::PH_BRAKE) ? brake_cur :
                        (phase_ff == msr_pkg::PH_PREEX) ? preex_cur :
                        (phase_ff == msr_pkg::PH_SEARCH) ? srch_cur : 16'h0000;
      search_gain_ff <= gain;
      rev_dir_ff <= dir_ff;
      out_enable_ff <= phase_ff != msr_pkg::PH_IDLE;
      dc_brake_ff <= phase_ff == msr_pkg::PH_BRAKE;
      preexcite_ff <= phase_ff == msr_pkg::PH_PREEX;
      search_active_ff <= phase_ff == msr_pkg::PH_SEARCH;
    end
  end
  assign freq_ref = freq_ref_ff;
  assign current_ref = current_ref_ff;
  assign search_gain = search_gain_ff;
  assign rev_dir = rev_dir_ff;
  assign out_enable = out_enable_ff;
  assign dc_brake = dc_brake_ff;
  assign preexcite = preexcite_ff;
  assign search_active = search_active_ff;
  // ==========================================================
  // ahb-lite slave, zero wait states, always okay
  logic addr_ok;
  logic [3:0] a_idx;
  assign a_idx = haddr[5:2];
  assign addr_ok = hsel && hready && htrans[1];
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_pend_ff <= 1'b0;
      wr_hit_ff <= 1'b0;
      wr_idx_ff <= 4'h0;
      hrdata_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      replan_ff <= 1'b0;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      wr_pend_ff <= addr_ok && hwrite;
      wr_idx_ff <= a_idx;
      wr_hit_ff <= haddr[31:6] == 26'h0000000 && 32'(a_idx) < msr_pkg::CFG_N;
      // a new setpoint or ramp time abandons a running intermittent S curve
      replan_ff <= wr_pend_ff && wr_hit_ff && shape == 2'h2 &&
                   (wr_idx_ff == msr_pkg::IDX_SETF || wr_idx_ff == msr_pkg::IDX_ACCDEC);
      if (addr_ok && !hwrite) begin
        if (haddr[31:6] != 26'h0000000) begin
          hrdata_ff <= 32'h0000_0000;
        end else if (32'(a_idx) < msr_pkg::CFG_N) begin
          hrdata_ff <= cfg_ff[a_idx];
        end else if (a_idx == msr_pkg::IDX_STAT) begin
          hrdata_ff <= {26'h0000000, out_enable_ff, flipped_ff, dir_ff, phase_ff};
        end else if (a_idx == msr_pkg::IDX_FREQ) begin
          hrdata_ff <= {16'h0000, cur_ff[31:16]};
        end else begin
          hrdata_ff <= 32'h0000_0000;
        end
      end
    end
  end
  // configuration words, written in the data phase
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < msr_pkg::CFG_N; i++) begin
        cfg_ff[i] <= msr_pkg::CFG_RST[i];
      end
    end else if (wr_pend_ff && wr_hit_ff) begin
      cfg_ff[wr_idx_ff] <= hwdata;
    end
  end
  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_direct_go;
    phase_ff == msr_pkg::PH_IDLE && run_cmd && !method_search && !replan_ff;
  endsequence
  sequence s_search_go;
    phase_ff == msr_pkg::PH_IDLE && run_cmd && method_search && !replan_ff;
  endsequence
  coast_stop_a: assert property (
    phase_ff != msr_pkg::PH_IDLE && !run_cmd && stop_coast
    |=> phase_ff == msr_pkg::PH_IDLE ##1 !out_enable_ff && freq_ref_ff == 16'h0000)
    else $error("coast stop did not cut output");
  brake_skip_a: assert property (
    s_direct_go and brake_t == 16'h0000 |=> phase_ff != msr_pkg::PH_BRAKE)
    else $error("start braking not skipped");
  preex_skip_a: assert property (
    s_direct_go and brake_t == 16'h0000 && preex_t == 16'h0000
    |=> phase_ff != msr_pkg::PH_PREEX)
    else $error("preexcitation not skipped");
  start_freq_a: assert property (
    s_direct_go |=> cur_ff[31:16] == $past(start_f))
    else $error("start frequency altered");
  brake_order_a: assert property (
    phase_ff == msr_pkg::PH_BRAKE && tick_ff && run_cmd && !replan_ff &&
    timer_ff + 16'h0001 >= brake_t && preex_t != 16'h0000 |=> phase_ff == msr_pkg::PH_PREEX)
    else $error("braking not followed by preexcitation");
  brake_current_a: assert property (
    phase_ff == msr_pkg::PH_BRAKE |=> dc_brake_ff && current_ref_ff == $past(brake_cur))
    else $error("braking current wrong");
  hold_wait_a: assert property (
    phase_ff == msr_pkg::PH_HOLD && !tick_ff && run_cmd |=> phase_ff == msr_pkg::PH_HOLD)
    else $error("hold left between ticks");
  search_origin_a: assert property (
    s_search_go |=> phase_ff == msr_pkg::PH_SEARCH && cur_ff[31:16] == $past(origin))
    else $error("search origin wrong");
  search_limit_a: assert property (
    phase_ff == msr_pkg::PH_SEARCH |=> search_active_ff && current_ref_ff == $past(srch_cur))
    else $error("tracking current wrong");
  search_flip_a: assert property (
    phase_ff == msr_pkg::PH_SEARCH && tick_ff && run_cmd && !replan_ff && !speed_match &&
    cur_ff <= sstep && tens_one && !flipped_ff
    |=> phase_ff == msr_pkg::PH_SEARCH && dir_ff != $past(dir_ff))
    else $error("search did not reverse");
  ramp_bound_a: assert property (
    phase_ff == msr_pkg::PH_RUN && run_cmd && cur_ff <= tgt32 |=> cur_ff <= $past(tgt32))
    else $error("ramp overshot setpoint");
  replan_a: assert property (
    replan_ff && run_cmd && phase_ff == msr_pkg::PH_RUN |=> slope_ff == 32'h0000_0000)
    else $error("S curve not replanned");
endmodule : msr_start_ramp

// [sim/msr_motor_model.sv]
`timescale 1ns/1ns
// ==========================================================
// spinning motor as seen through the modulation stage
module msr_motor_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // from the sequencer
  input wire logic [15:0] freq_ref,
  input wire logic rev_dir,
  input wire logic search_active,
  // shaft state chosen by the bench
  input wire logic [15:0] motor_freq,
  input wire logic motor_rev,
  // back to current control
  output logic speed_match
);
  // match only in the shaft direction and only once the scan is down to shaft speed
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      speed_match <= 1'b0;
    end else begin
      speed_match <= search_active && motor_freq != 16'h0000 && rev_dir == motor_rev
        && freq_ref <= motor_freq;
    end
  end
endmodule : msr_motor_model

// [sim/test_motor_start_ramp_sequencer.sv]
`timescale 1ns/1ns
// ==========================================================
// start and ramp sequencer bench
module test_motor_start_ramp_sequencer;
  localparam int TK = 20;
  logic sys_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, mrev = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, speed_match, rev_dir, out_enable, dc_brake, preexcite;
  logic search_active;
  logic [15:0] freq_ref, current_ref, search_gain, mfreq = 16'h0, sf, tgt, org;
  int err_count = 0, samples_checked = 0, cyc = 0, n = 0, phase_seen = 0, over_seen = 0, snap = 0;
  // ==========================================================
  msr_start_ramp #(.TICK_CYCLES(TK)) DUT (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .speed_match(speed_match), .freq_ref(freq_ref), .rev_dir(rev_dir),
    .out_enable(out_enable), .dc_brake(dc_brake), .preexcite(preexcite),
    .search_active(search_active), .current_ref(current_ref), .search_gain(search_gain));
  msr_motor_model motor (.sys_clk(sys_clk), .rst(rst), .freq_ref(freq_ref), .rev_dir(rev_dir),
    .search_active(search_active), .motor_freq(mfreq), .motor_rev(mrev),
    .speed_match(speed_match));
  always #5 sys_clk = ~sys_clk;
  // hang guard: far above the ten thousand or so cycles the tests need
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      complete_run();
    end
  end
  // count start phases and overshoots between the bench's own samples;
  // scans start above the setpoint, so search time is left out
  always @(negedge sys_clk) begin
    if (dc_brake === 1'b1 || preexcite === 1'b1) begin
      phase_seen++;
    end
    if (freq_ref > tgt && search_active === 1'b0) begin
      over_seen++;
    end
  end
  // ==========================================================
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] w);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : bus
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  function automatic logic cond(input int k);
    case (k)
      0: return dc_brake === 1'b1;
      1: return preexcite === 1'b1;
      2: return search_active === 1'b1;
      3: return out_enable === 1'b0;
      4: return freq_ref === tgt && out_enable === 1'b1;
      5: return freq_ref !== 16'h0 && out_enable === 1'b1;
      default: return rev_dir === 1'b1 && search_active === 1'b1;
    endcase
  endfunction : cond
  // wait for a condition (lv=1) or for its end (lv=0), counting cycles, bounded
  task automatic wait_for(input int k, input logic lv);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (cond(k) !== lv && n < 20000);
    if (n >= 20000) chk(1'b0, "wait ran out");
  endtask : wait_for
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  // ==========================================================
  initial begin
    void'($urandom(32'h4260826C));
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    // reset values, read-only and unmapped places
    for (int i = 0; i < msr_pkg::CFG_N; i++) begin
      bus(1'b0, i * 4, 32'h0);
      chk(d === msr_pkg::CFG_RST[i], "reset value");
    end
    bus(1'b1, 32'h2C, 32'hFFFF_FFFF);
    bus(1'b0, 32'h2C, 32'h0);
    chk(d[2:0] === 3'h0, "status written");
    bus(1'b0, 32'h40, 32'h0);
    chk(d === 32'h0, "unmapped read");
    chk(hresp === 1'b0 && hreadyout === 1'b1, "bus response okay");
    $display("test registers done");
    // direct start through every phase, then ramp stop
    sf = 16'($urandom_range(1000, 1));
    tgt = 16'($urandom_range(3000, 1500));
    bus(1'b1, 32'h04, {16'h0, tgt});
    bus(1'b1, 32'h08, {16'h2, sf});
    bus(1'b1, 32'h0C, {16'h3, 16'h01F4});
    bus(1'b1, 32'h10, {16'h2, 16'h05DC});
    bus(1'b1, 32'h1C, 32'h000A_000A);
    bus(1'b1, 32'h28, 32'h0BB8_1388);
    bus(1'b1, 32'h00, 32'h1);
    wait_for(0, 1'b1);
    chk(current_ref === 16'h01F4, "brake current");
    wait_for(0, 1'b0);
    chk(n >= 2 * TK && n <= 4 * TK, "brake length");
    wait_for(1, 1'b1);
    chk(current_ref === 16'h05DC && dc_brake === 1'b0, "preexcite current");
    wait_for(1, 1'b0);
    chk(n >= TK && n <= 3 * TK, "preexcite length");
    wait_for(5, 1'b1);
    chk(freq_ref === sf, "start frequency");
    bus(1'b0, 32'h30, 32'h0);
    chk(d[15:0] === sf, "present frequency");
    wait_for(4, 1'b1);
    chk(n >= (tgt - sf) / 50 * TK && n <= ((tgt - sf) / 50 + 5) * TK, "linear ramp");
    bus(1'b1, 32'h00, 32'h0);
    wait_for(3, 1'b1);
    chk(n >= (tgt / 50 - 2) * TK, "ramp stop");
    $display("test direct start done");
    // zero brake and preexcite times, then coast stop
    bus(1'b1, 32'h0C, {16'h0, 16'h01F4});
    bus(1'b1, 32'h10, {16'h0, 16'h05DC});
    snap = phase_seen;
    bus(1'b1, 32'h00, 32'h1);
    wait_for(4, 1'b1);
    chk(phase_seen == snap, "phases skipped");
    bus(1'b1, 32'h00, 32'h8);
    wait_for(3, 1'b1);
    chk(n <= 4, "coast stop");
    $display("test skip and coast done");
    // speed search from each origin, motor turning forward
    mfreq <= 16'h03E8;
    for (int k = 0; k < 3; k++) begin
      org = (k == 0) ? 16'h1388 : (k == 1) ? tgt : 16'h0BB8;
      bus(1'b1, 32'h14, {16'h01F4, 8'h01, 8'(k)});
      bus(1'b1, 32'h00, 32'h5);
      wait_for(2, 1'b1);
      chk(current_ref === 16'h01F4, "search current");
      chk(search_gain === 16'h0064, "search gain");
      repeat (TK) @(negedge sys_clk);
      chk(freq_ref <= org && freq_ref + 16'h044C >= org, "search origin");
      wait_for(2, 1'b0);
      chk(k != 0 || (n >= 5 * TK && n <= 10 * TK), "scan rate");
      chk(freq_ref <= 16'h03E8 && freq_ref >= 16'h012C, "resume speed");
      wait_for(4, 1'b1);
      bus(1'b1, 32'h00, 32'h8);
      wait_for(3, 1'b1);
    end
    // motor turning backward: second direction allowed, then refused
    mrev <= 1'b1;
    bus(1'b1, 32'h14, {16'h01F4, 8'h01, 8'h10});
    bus(1'b1, 32'h00, 32'h5);
    wait_for(6, 1'b1);
    wait_for(4, 1'b1);
    chk(rev_dir === 1'b1, "reverse search");
    bus(1'b1, 32'h00, 32'h8);
    wait_for(3, 1'b1);
    bus(1'b1, 32'h14, {16'h01F4, 8'h01, 8'h00});
    // doubled gain halves the scan time; unity gain would need ten ticks
    bus(1'b1, 32'h18, 32'h0000_00C8);
    bus(1'b1, 32'h00, 32'h5);
    wait_for(2, 1'b1);
    wait_for(2, 1'b0);
    chk(freq_ref <= 16'h0258 && rev_dir === 1'b0, "zero speed start");
    chk(n <= 6 * TK && search_gain === 16'h00C8, "doubled scan gain");
    bus(1'b1, 32'h00, 32'h8);
    wait_for(3, 1'b1);
    $display("test speed search done");
    // both s-curve shapes with a ramp time change mid-ramp
    for (int s = 1; s < 3; s++) begin
      bus(1'b1, 32'h1C, 32'h000A_000A);
      bus(1'b1, 32'h00, {26'h0, 2'(s), 4'h1});
      repeat (3 * TK) @(posedge sys_clk);
      bus(1'b1, 32'h1C, 32'h0005_0005);
      wait_for(4, 1'b1);
      chk(over_seen == 0, "no overshoot");
      bus(1'b1, 32'h00, 32'h8);
      wait_for(3, 1'b1);
    end
    $display("test ramp shapes done");
    complete_run();
  end
endmodule : test_motor_start_ramp_sequencer
